/* hdl/rtc_pkg.sv */
// constants shared by the real-time counter and tick timer design
// assumes one bus clock; the slow clock arrives as a sampled pin
package rtc_pkg;
    // register byte offsets
    localparam logic [4:0] OFS_MAIN_CONTROL = 5'h00;
    localparam logic [4:0] OFS_COUNTER_SYNC_STATE = 5'h01;
    localparam logic [4:0] OFS_EVENT_ENABLES = 5'h02;
    localparam logic [4:0] OFS_EVENT_FLAGS = 5'h03;
    localparam logic [4:0] OFS_WIDE_ACCESS_LATCH = 5'h04;
    localparam logic [4:0] OFS_HALT_CONTROL = 5'h05;
    localparam logic [4:0] OFS_CRYSTAL_PPM_TRIM = 5'h06;
    localparam logic [4:0] OFS_SOURCE_SELECT = 5'h07;
    localparam logic [4:0] OFS_COUNT_LO = 5'h08;
    localparam logic [4:0] OFS_COUNT_HI = 5'h09;
    localparam logic [4:0] OFS_TOP_LO = 5'h0A;
    localparam logic [4:0] OFS_TOP_HI = 5'h0B;
    localparam logic [4:0] OFS_MATCH_LO = 5'h0C;
    localparam logic [4:0] OFS_MATCH_HI = 5'h0D;
    localparam logic [4:0] OFS_TICK_CONTROL = 5'h10;
    localparam logic [4:0] OFS_TICK_STATE = 5'h11;
    localparam logic [4:0] OFS_TICK_ENABLES = 5'h12;
    localparam logic [4:0] OFS_TICK_FLAGS = 5'h13;
    localparam logic [4:0] OFS_TICK_HALT_CONTROL = 5'h15;

    // field positions
    localparam int MAIN_KEEP_ALIVE_BIT = 7;
    localparam int MAIN_DIV_LSB = 3;
    localparam int MAIN_DIV_MSB = 6;
    localparam int MAIN_DRIFT_FIX_BIT = 2;
    localparam int MAIN_ENABLE_BIT = 0;
    localparam int TICK_PERIOD_LSB = 3;
    localparam int TICK_PERIOD_MSB = 6;
    localparam int TICK_ENABLE_BIT = 0;
    localparam int OVERFLOW_EVENT_BIT = 0;
    localparam int MATCH_EVENT_BIT = 1;
    localparam int TICK_IRQ_BIT = 0;
    localparam int RUN_WHEN_HALTED_BIT = 0;
    localparam int PPM_SIGN_BIT = 7;

    // busy bits in the counter sync state register
    localparam int BUSY_CONTROL_BIT = 0;
    localparam int BUSY_COUNT_BIT = 1;
    localparam int BUSY_TOP_BIT = 2;
    localparam int BUSY_MATCH_BIT = 3;

    // writable masks and reset values
    localparam logic [7:0] MAIN_CONTROL_MASK = 8'hFD;
    localparam logic [7:0] TICK_CONTROL_MASK = 8'h79;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [15:0] TOP_RESET = 16'hFFFF;
    localparam logic [15:0] WIDE_RESET = 16'h0000;

    // tick period codes that produce a wave
    localparam logic [3:0] TICK_CODE_MIN = 4'h1;
    localparam logic [3:0] TICK_CODE_MAX = 4'hE;

    // slow clock edges a written value spends crossing over
    localparam int SYNC_EDGES = 2;
    // correction slots per correction interval
    localparam int CORR_SLOTS = 128;
    localparam int PRESCALE_WIDTH = 15;

    typedef enum logic [0:0] {
        SYNC_IDLE = 1'b0,
        SYNC_WAIT = 1'b1
    } rtc_sync_e;
endpackage : rtc_pkg

/* hdl/rtc_edge_sync.sv */
// two-stage synchroniser with rising-edge detect for the slow clock pin
// assumes the pin is far slower than clock
`timescale 1ns/1ps
module rtc_edge_sync
    import rtc_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic pin,
    output logic rise
);
    logic stage1;
    logic stage2;
    logic stage3;

    // stage1 feeds stage2 only, edge is taken after it
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end
        else
        begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    assign rise = stage2 & ~stage3;
endmodule : rtc_edge_sync

/* hdl/rtc_write_sync.sv */
// holds a written value and releases it after a fixed count of slow edges
// assumes slow_edge is a one-cycle pulse per slow clock rising edge
`timescale 1ns/1ps
module rtc_write_sync
    import rtc_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_data,
    input wire logic slow_edge,
    output logic busy,
    output logic apply,
    output logic [WIDTH-1:0] data
);
    rtc_sync_e state;
    logic [1:0] edges;

    // a new write while waiting restarts the crossing with fresh data
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state <= SYNC_IDLE;
            edges <= 2'h0;
            apply <= 1'b0;
        end
        else
        begin
            apply <= 1'b0;
            case (state)
                SYNC_IDLE:
                begin
                    if (load)
                    begin
                        state <= SYNC_WAIT;
                        edges <= 2'h0;
                    end
                end
                SYNC_WAIT:
                begin
                    if (load)
                        edges <= 2'h0;
                    else if (slow_edge)
                    begin
                        if (edges == 2'(SYNC_EDGES - 1))
                        begin
                            state <= SYNC_IDLE;
                            apply <= 1'b1;
                        end
                        edges <= edges + 2'h1;
                    end
                end
                default: state <= SYNC_IDLE;
            endcase
        end
    end

    // shadow copy seen by software until it lands
    always_ff @(posedge clock)
    begin
        if (srst)
            data <= RESET_VALUE;
        else if (load)
            data <= load_data;
    end

    assign busy = (state == SYNC_WAIT) | apply;
endmodule : rtc_write_sync

/* hdl/rtc_core.sv */
// real-time counter and periodic tick timer with byte register port
// assumes slow_clock is an async pin, far slower than clock; debug_halt
// and standby come from logic on clock
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
module rtc_core
    import rtc_pkg::*;
#(
    parameter int CORR_INTERVAL = 1000000
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic slow_clock,
    input wire logic standby_sleep,
    input wire logic debug_halt,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic counter_irq,
    output logic tick_irq,
    output logic tick_wave
);
    localparam int CORR_STEP = CORR_INTERVAL / CORR_SLOTS;

    // prescale mask for a divider code
    function automatic logic [PRESCALE_WIDTH-1:0] div_mask(input logic [3:0] code);
        div_mask = PRESCALE_WIDTH'((32'h1 << code) - 32'h1);
    endfunction : div_mask

    // one-cycle write strobe for a given offset
    function automatic logic wr_at(input logic [4:0] ofs, input logic [4:0] addr,
                                   input logic wr);
        wr_at = wr & (addr == ofs);
    endfunction : wr_at

    logic slow_edge;
    logic [7:0] halt_control;
    logic [7:0] tick_halt_control;
    logic [7:0] crystal_ppm_trim;
    logic [7:0] source_select;
    logic [7:0] event_enables;
    logic [7:0] tick_enables;
    logic [1:0] event_flags;
    logic tick_flag;
    logic [7:0] wide_access_latch;
    logic [7:0] main_active;
    logic [7:0] tick_active;
    logic [15:0] count_value;
    logic [15:0] top_active;
    logic [15:0] match_active;
    logic [PRESCALE_WIDTH-1:0] prescale;
    logic [31:0] corr_cycle;
    logic [6:0] corr_slot;
    logic tick_prev;

    // crossing units
    logic ctrl_busy, ctrl_apply;
    logic [7:0] ctrl_data;
    logic tick_busy, tick_apply;
    logic [7:0] tick_data;
    logic count_busy, count_apply;
    logic [15:0] count_data;
    logic top_busy, top_apply;
    logic [15:0] top_data;
    logic match_busy, match_apply;
    logic [15:0] match_data;

    logic wr_count_hi;
    logic wr_top_hi;
    logic wr_match_hi;
    logic counter_run;
    logic prescale_run;
    logic corr_now;
    logic corr_hold;
    logic corr_skip;
    logic counter_step;
    logic overflow_hit;
    logic match_hit;
    logic [15:0] next_count;
    logic [3:0] tick_code;
    logic tick_rise;

    rtc_edge_sync u_slow_sync (
        .clock(clock), .srst(srst),
        .pin(slow_clock), .rise(slow_edge)
    );

    assign wr_count_hi = wr_at(OFS_COUNT_HI, reg_addr, reg_wr);
    assign wr_top_hi = wr_at(OFS_TOP_HI, reg_addr, reg_wr);
    assign wr_match_hi = wr_at(OFS_MATCH_HI, reg_addr, reg_wr);

    // every slow-domain write waits for the edge count before landing
    rtc_write_sync #(.WIDTH(8), .RESET_VALUE(REG_RESET)) u_ctrl_sync (
        .clock(clock), .srst(srst), .slow_edge(slow_edge),
        .load(wr_at(OFS_MAIN_CONTROL, reg_addr, reg_wr)),
        .load_data(reg_wdata & MAIN_CONTROL_MASK),
        .busy(ctrl_busy), .apply(ctrl_apply), .data(ctrl_data)
    );

    rtc_write_sync #(.WIDTH(8), .RESET_VALUE(REG_RESET)) u_tick_sync (
        .clock(clock), .srst(srst), .slow_edge(slow_edge),
        .load(wr_at(OFS_TICK_CONTROL, reg_addr, reg_wr)),
        .load_data(reg_wdata & TICK_CONTROL_MASK),
        .busy(tick_busy), .apply(tick_apply), .data(tick_data)
    );

    rtc_write_sync #(.WIDTH(16), .RESET_VALUE(WIDE_RESET)) u_count_sync (
        .clock(clock), .srst(srst), .slow_edge(slow_edge),
        .load(wr_count_hi), .load_data({reg_wdata, wide_access_latch}),
        .busy(count_busy), .apply(count_apply), .data(count_data)
    );

    rtc_write_sync #(.WIDTH(16), .RESET_VALUE(TOP_RESET)) u_top_sync (
        .clock(clock), .srst(srst), .slow_edge(slow_edge),
        .load(wr_top_hi), .load_data({reg_wdata, wide_access_latch}),
        .busy(top_busy), .apply(top_apply), .data(top_data)
    );

    rtc_write_sync #(.WIDTH(16), .RESET_VALUE(WIDE_RESET)) u_match_sync (
        .clock(clock), .srst(srst), .slow_edge(slow_edge),
        .load(wr_match_hi), .load_data({reg_wdata, wide_access_latch}),
        .busy(match_busy), .apply(match_apply), .data(match_data)
    );

    // plain control registers, effective at once
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            halt_control <= REG_RESET;
            tick_halt_control <= REG_RESET;
            crystal_ppm_trim <= REG_RESET;
            source_select <= REG_RESET;
            event_enables <= REG_RESET;
            tick_enables <= REG_RESET;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                OFS_HALT_CONTROL: halt_control <= {7'h00, reg_wdata[RUN_WHEN_HALTED_BIT]};
                OFS_TICK_HALT_CONTROL: tick_halt_control <= {7'h00, reg_wdata[0]};
                OFS_CRYSTAL_PPM_TRIM: crystal_ppm_trim <= reg_wdata;
                OFS_SOURCE_SELECT: source_select <= {6'h00, reg_wdata[1:0]};
                OFS_EVENT_ENABLES: event_enables <= {6'h00, reg_wdata[1:0]};
                OFS_TICK_ENABLES: tick_enables <= {7'h00, reg_wdata[TICK_IRQ_BIT]};
                default: ;
            endcase
        end
    end

    // shared byte latch: low byte write parks, low byte read snapshots high
    always_ff @(posedge clock)
    begin
        if (srst)
            wide_access_latch <= REG_RESET;
        else if (reg_wr && reg_addr inside {OFS_WIDE_ACCESS_LATCH, OFS_COUNT_LO,
                                            OFS_TOP_LO, OFS_MATCH_LO})
            wide_access_latch <= reg_wdata;
        else if (reg_rd)
        begin
            case (reg_addr)
                OFS_COUNT_LO: wide_access_latch <= count_value[15:8];
                OFS_TOP_LO: wide_access_latch <= top_data[15:8];
                OFS_MATCH_LO: wide_access_latch <= match_data[15:8];
                default: ;
            endcase
        end
    end

    // landed copies that actually steer the slow-domain logic
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            main_active <= REG_RESET;
            tick_active <= REG_RESET;
            top_active <= TOP_RESET;
            match_active <= WIDE_RESET;
        end
        else
        begin
            if (ctrl_apply)
                main_active <= ctrl_data;
            if (tick_apply)
                tick_active <= tick_data;
            if (top_apply)
                top_active <= top_data;
            if (match_apply)
                match_active <= match_data;
        end
    end

    // idle sleep has no term here: only standby and halt gate the counter
    assign counter_run = main_active[MAIN_ENABLE_BIT]
        & ~(standby_sleep & ~main_active[MAIN_KEEP_ALIVE_BIT])
        & ~(debug_halt & ~halt_control[RUN_WHEN_HALTED_BIT]);
    // one chain for both users, idle only when both are off
    assign prescale_run = main_active[MAIN_ENABLE_BIT] | tick_active[TICK_ENABLE_BIT];

    // correction: one slot per step, the first trim slots adjust a cycle
    assign corr_now = main_active[MAIN_DRIFT_FIX_BIT] & (corr_slot < crystal_ppm_trim[6:0])
        & (corr_cycle == 32'(CORR_STEP - 1));
    assign corr_hold = corr_now & ~crystal_ppm_trim[PPM_SIGN_BIT];
    assign corr_skip = corr_now & crystal_ppm_trim[PPM_SIGN_BIT];

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            corr_cycle <= 32'h0;
            corr_slot <= 7'h00;
        end
        else if (slow_edge && prescale_run)
        begin
            if (corr_cycle == 32'(CORR_STEP - 1))
            begin
                corr_cycle <= 32'h0;
                corr_slot <= corr_slot + 7'h01;
            end
            else
                corr_cycle <= corr_cycle + 32'h1;
        end
    end

    // shared prescaler; hold slows, double step speeds up
    always_ff @(posedge clock)
    begin
        if (srst)
            prescale <= '0;
        else if (!prescale_run)
            prescale <= '0;
        else if (slow_edge && !corr_hold)
            prescale <= prescale + (corr_skip ? PRESCALE_WIDTH'(2) : PRESCALE_WIDTH'(1));
    end

    // counter steps when the low divider bits of the chain are all ones
    assign counter_step = slow_edge & counter_run & ~corr_hold
        & ((prescale & div_mask(main_active[MAIN_DIV_MSB:MAIN_DIV_LSB]))
           == div_mask(main_active[MAIN_DIV_MSB:MAIN_DIV_LSB]));
    assign overflow_hit = counter_step & (count_value == top_active);
    assign next_count = overflow_hit ? 16'h0000 : count_value + 16'h0001;
    assign match_hit = counter_step & (next_count == match_active);

    // count value, a landed software write takes precedence
    always_ff @(posedge clock)
    begin
        if (srst)
            count_value <= WIDE_RESET;
        else if (count_apply)
            count_value <= count_data;
        else if (counter_step)
            count_value <= next_count;
    end

    // tick wave follows a chain bit; halt forces it low unless the tick run-when-halted bit is set
    assign tick_code = tick_active[TICK_PERIOD_MSB:TICK_PERIOD_LSB];
    always_ff @(posedge clock)
    begin
        if (srst)
            tick_wave <= 1'b0;
        else
            tick_wave <= tick_active[TICK_ENABLE_BIT]
                & (tick_code >= TICK_CODE_MIN) & (tick_code <= TICK_CODE_MAX)
                & prescale[tick_code]
                & ~(debug_halt & ~tick_halt_control[RUN_WHEN_HALTED_BIT]);
    end

    // a high wave forced low by halt rises again on resume if its chain bit is still high
    always_ff @(posedge clock)
    begin
        if (srst)
            tick_prev <= 1'b0;
        else
            tick_prev <= tick_wave;
    end
    assign tick_rise = tick_wave & ~tick_prev;

    // sticky flags; a same-cycle event beats the software clear
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            event_flags <= 2'b00;
            tick_flag <= 1'b0;
        end
        else
        begin
            event_flags[OVERFLOW_EVENT_BIT] <= overflow_hit
                | (event_flags[OVERFLOW_EVENT_BIT]
                   & ~(wr_at(OFS_EVENT_FLAGS, reg_addr, reg_wr)
                       & reg_wdata[OVERFLOW_EVENT_BIT]));
            event_flags[MATCH_EVENT_BIT] <= match_hit
                | (event_flags[MATCH_EVENT_BIT]
                   & ~(wr_at(OFS_EVENT_FLAGS, reg_addr, reg_wr)
                       & reg_wdata[MATCH_EVENT_BIT]));
            tick_flag <= tick_rise
                | (tick_flag & ~(wr_at(OFS_TICK_FLAGS, reg_addr, reg_wr)
                                 & reg_wdata[TICK_IRQ_BIT]));
        end
    end

    // two request lines, one per vector
    assign counter_irq = |(event_flags & event_enables[1:0]);
    assign tick_irq = tick_flag & tick_enables[TICK_IRQ_BIT];

    // read data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge clock)
    begin
        if (srst)
            reg_rdata <= REG_RESET;
        else if (!reg_rd)
            reg_rdata <= REG_RESET;
        else
        begin
            case (reg_addr)
                OFS_MAIN_CONTROL: reg_rdata <= ctrl_data;
                OFS_COUNTER_SYNC_STATE: reg_rdata <= {4'h0, match_busy, top_busy,
                                                      count_busy, ctrl_busy};
                OFS_EVENT_ENABLES: reg_rdata <= event_enables;
                OFS_EVENT_FLAGS: reg_rdata <= {6'h00, event_flags};
                OFS_WIDE_ACCESS_LATCH: reg_rdata <= wide_access_latch;
                OFS_HALT_CONTROL: reg_rdata <= halt_control;
                OFS_CRYSTAL_PPM_TRIM: reg_rdata <= crystal_ppm_trim;
                OFS_SOURCE_SELECT: reg_rdata <= source_select;
                OFS_COUNT_LO: reg_rdata <= count_value[7:0];
                OFS_TOP_LO: reg_rdata <= top_data[7:0];
                OFS_MATCH_LO: reg_rdata <= match_data[7:0];
                OFS_COUNT_HI, OFS_TOP_HI, OFS_MATCH_HI: reg_rdata <= wide_access_latch;
                OFS_TICK_CONTROL: reg_rdata <= tick_data;
                OFS_TICK_STATE: reg_rdata <= {7'h00, tick_busy};
                OFS_TICK_ENABLES: reg_rdata <= tick_enables;
                OFS_TICK_FLAGS: reg_rdata <= {7'h00, tick_flag};
                OFS_TICK_HALT_CONTROL: reg_rdata <= tick_halt_control;
                default: reg_rdata <= REG_RESET;
            endcase
        end
    end
endmodule : rtc_core

/* bench/rtc_core_asserts.sv */
// port checker for the counter and tick block
// sees only the top ports; shadows the enable bits and the tick halt bit from writes
`timescale 1ns/1ps
module rtc_core_chk
#(
    parameter int CORR_INTERVAL = 1000000
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic slow_clock,
    input wire logic standby_sleep,
    input wire logic debug_halt,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic counter_irq,
    input wire logic tick_irq,
    input wire logic tick_wave
);
    logic [1:0] en_c;
    logic en_t;
    logic run_t;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // enables and halt bits act at once, so a write-edge shadow is exact
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            en_c <= 2'h0;
            en_t <= 1'b0;
            run_t <= 1'b0;
        end
        else if (reg_wr && reg_addr == 5'h02)
            en_c <= reg_wdata[1:0];
        else if (reg_wr && reg_addr == 5'h12)
            en_t <= reg_wdata[0];
        else if (reg_wr && reg_addr == 5'h15)
            run_t <= reg_wdata[0];
    end
    chk_reset_quiet: assert property ($fell(srst) |-> !counter_irq && !tick_irq && !tick_wave)
        else $error("outputs not quiet after reset");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its slot");
    chk_rsvd_read: assert property (reg_rd && reg_addr == 5'h0E |=> reg_rdata == 8'h00)
        else $error("reserved place reads nonzero");
    chk_irq_needs_en: assert property (counter_irq |-> en_c != 2'h0)
        else $error("counter irq without enable");
    chk_irq_holds: assert property (counter_irq && !(reg_wr && reg_addr[4:1] == 4'h1)
        |=> counter_irq)
        else $error("counter irq dropped");
    chk_tirq_needs_en: assert property (tick_irq |-> en_t)
        else $error("tick irq without enable");
    chk_tirq_holds: assert property (tick_irq && !(reg_wr && reg_addr[4:1] == 4'h9)
        |=> tick_irq)
        else $error("tick irq dropped");
    chk_halt_low: assert property ((debug_halt && !run_t)[*2] |-> !tick_wave)
        else $error("tick wave high in halt");
    chk_tick_flag: assert property ($rose(tick_wave) && en_t |-> ##[0:2] tick_irq)
        else $error("tick rise without flag");
    cover property ($rose(counter_irq));
    cover property ($rose(tick_wave));
    cover property (debug_halt && tick_wave);
endmodule : rtc_core_chk

bind rtc_core rtc_core_chk #(.CORR_INTERVAL(CORR_INTERVAL)) rtc_core_chk_inst (
    .clock(clock), .srst(srst), .slow_clock(slow_clock), .standby_sleep(standby_sleep),
    .debug_halt(debug_halt), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .counter_irq(counter_irq),
    .tick_irq(tick_irq), .tick_wave(tick_wave));

/* bench/test_rtc_core.sv */
// self-checking bench for the counter and tick block
// drives the register port and the slow clock pin itself
`timescale 1ns/1ps
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin mismatches++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, s); end end
module test_rtc_core;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic slow_clock = 1'b0;
    logic standby_sleep = 1'b0;
    logic debug_halt = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic counter_irq;
    logic tick_irq;
    logic tick_wave;
    logic wave_q = 1'b0;
    logic [7:0] v;
    logic [7:0] r;
    int rises = 0;
    int mismatches = 0;
    int num_checks = 0;
    int n;
    logic [4:0] ra [18] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
        5'h0A, 5'h0B, 5'h0C, 5'h10, 5'h11, 5'h12, 5'h13, 5'h15, 5'h0E};
    // short count keeps the correction interval cheap to simulate
    rtc_core #(.CORR_INTERVAL(256)) rtc_core_inst (.clock(clock), .srst(srst),
        .slow_clock(slow_clock), .standby_sleep(standby_sleep), .debug_halt(debug_halt),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .counter_irq(counter_irq), .tick_irq(tick_irq),
        .tick_wave(tick_wave));
    initial
    begin
        forever #10 clock = ~clock;
    end
    // count tick rises as the model of the tick interval
    always @(posedge clock)
    begin
        wave_q <= tick_wave;
        if (tick_wave && !wave_q)
            rises <= rises + 1;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    // data stands only in the cycle after the taking edge
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic rchk(input logic [4:0] a, input logic [7:0] e);
        rd(a, v);
        `CHK($sformatf("reg %0h", a), e, v)
    endtask : rchk
    // pin high four cycles, low four: the pin must stay at or below clock/4
    task automatic slow(input int k);
        repeat (k)
        begin
            slow_clock <= 1'b1;
            repeat (4) @(posedge clock);
            slow_clock <= 1'b0;
            repeat (4) @(posedge clock);
        end
    endtask : slow
    // busy only clears on slow edges, so feed them while polling
    task automatic settle(input logic [4:0] a);
        for (int i = 0; i < 20; i++)
        begin
            rd(a, v);
            if (v === 8'h00)
                return;
            slow(1);
        end
        mismatches++;
        end_sim();
    endtask : settle
    // top is 3, so the model counts modulo 4
    task automatic run(input int k, input int steps);
        logic [15:0] c0;
        logic [15:0] c1;
        rd(5'h08, c0[7:0]);
        rd(5'h09, c0[15:8]);
        slow(k);
        rd(5'h08, c1[7:0]);
        rd(5'h09, c1[15:8]);
        `CHK("count", 16'((c0 + steps) % 4), c1)
    endtask : run
    task automatic tcount(input int k, input int e);
        int r0;
        r0 = rises;
        slow(k);
        `CHK("tick rises", e, rises - r0)
    endtask : tcount
    initial
    begin
        void'($urandom(32'h9c6d));
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        foreach (ra[i])
            rchk(ra[i], (ra[i] == 5'h0A || ra[i] == 5'h0B) ? 8'hFF : 8'h00);
        wr(5'h0E, 8'hFF);
        rchk(5'h0E, 8'h00);
        wr(5'h00, 8'hFE);
        rchk(5'h01, 8'h01);
        slow(1);
        rchk(5'h01, 8'h01);
        slow(1);
        rchk(5'h01, 8'h00);
        rchk(5'h00, 8'hFC);
        wr(5'h10, 8'hFE);
        rchk(5'h11, 8'h01);
        settle(5'h11);
        rchk(5'h10, 8'h78);
        r = 8'($urandom);
        wr(5'h06, r);
        rchk(5'h06, r);
        $display("register access done");
        wr(5'h02, 8'h03);
        wr(5'h0A, 8'h03);
        wr(5'h0B, 8'h00);
        wr(5'h0C, 8'h02);
        wr(5'h0D, 8'h00);
        settle(5'h01);
        wr(5'h00, 8'h01);
        settle(5'h01);
        n = 4 + int'($urandom_range(5));
        run(n, n);
        rchk(5'h03, 8'h03);
        `CHK("counter_irq", 1'b1, counter_irq)
        `CHK("tick_irq", 1'b0, tick_irq)
        standby_sleep <= 1'b1;
        run(3, 0);
        wr(5'h00, 8'h81);
        settle(5'h01);
        run(3, 3);
        standby_sleep <= 1'b0;
        debug_halt <= 1'b1;
        run(3, 0);
        wr(5'h05, 8'h01);
        run(3, 3);
        debug_halt <= 1'b0;
        wr(5'h00, 8'h09);
        settle(5'h01);
        run(6, 3);
        wr(5'h00, 8'h00);
        settle(5'h01);
        run(4, 0);
        wr(5'h03, 8'h00);
        rchk(5'h03, 8'h03);
        wr(5'h03, 8'h01);
        rchk(5'h03, 8'h02);
        `CHK("counter_irq", 1'b1, counter_irq)
        wr(5'h02, 8'h01);
        #1;
        `CHK("counter_irq", 1'b0, counter_irq)
        $display("counter tests done");
        wr(5'h12, 8'h01);
        wr(5'h10, 8'h09);
        settle(5'h11);
        standby_sleep <= 1'b1;
        tcount(8, 2);
        `CHK("tick_irq", 1'b1, tick_irq)
        tcount(2, 1);
        wr(5'h13, 8'h01);
        debug_halt <= 1'b1;
        tcount(8, 0);
        n = rises;
        // wave was high when the halt began: resume must give one fresh rise
        debug_halt <= 1'b0;
        repeat (3) @(posedge clock);
        `CHK("resume rises", 1, rises - n)
        rchk(5'h13, 8'h01);
        wr(5'h15, 8'h01);
        debug_halt <= 1'b1;
        tcount(8, 2);
        debug_halt <= 1'b0;
        standby_sleep <= 1'b0;
        wr(5'h10, 8'h00);
        settle(5'h11);
        wr(5'h13, 8'h01);
        rchk(5'h13, 8'h00);
        `CHK("tick_irq", 1'b0, tick_irq)
        $display("tick tests done");
        end_sim();
    end
endmodule : test_rtc_core
